/* File: core/pbw_ctrl.sv */
// power-state controller: switch timing, wake sources, AC restore policy
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pbw_ctrl #(
  parameter int DEB_CYC   = int'(pbw_pkg::PBW_DEB_CYC),   // debounce cycles
  parameter int SHORT_CYC = int'(pbw_pkg::PBW_SHORT_CYC), // four-second count
  parameter int LONG_CYC  = int'(pbw_pkg::PBW_LONG_CYC)   // six-second count
) (
  input  wire logic              clk_i,        // standby clock 100 MHz
  input  wire logic              rst_i,        // sync reset, high
  input  wire logic              btn_i,        // power switch, high = pressed
  input  wire logic              ac_ok_i,      // main AC present (pin)
  input  wire pbw_pkg::pbw_wake_t wake_i,      // wake requests (pins), high
  input  wire logic [3:0]        addr_i,       // register address
  input  wire logic [31:0]       wdata_i,      // write data
  input  wire logic              wr_i,         // write strobe
  input  wire logic              rd_i,         // read strobe
  output logic [31:0]            rdata_o,      // read data, cycle after rd_i
  output logic                   main_pwr_o,   // main rails enabled (S0)
  output logic                   wake_pwr_o,   // wake logic rail enabled
  output logic                   display_on_o, // display out of sleep
  output logic                   cold_boot_o,  // boot is cold, no context
  output logic                   sleep_req_o,  // sleep request to os, level
  output pbw_pkg::pbw_state_t    state_o       // current power state
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [pbw_pkg::PBW_NWAKE:0] sy1_reg;
  logic [pbw_pkg::PBW_NWAKE:0] sy2_reg;
  pbw_pkg::pbw_wake_t          wk;
  logic                        ac_ok;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
    end else begin
      sy1_reg <= {ac_ok_i, wake_i};
      sy2_reg <= sy1_reg;
    end
  end

  assign wk    = sy2_reg[pbw_pkg::PBW_NWAKE-1:0];
  assign ac_ok = sy2_reg[pbw_pkg::PBW_NWAKE];

  // ------------------------------------------------------------
  // switch timer
  // ------------------------------------------------------------
  logic btn_short;
  logic btn_mid;
  logic btn_long;

  pbw_btn #(
    .DEB_CYC   (DEB_CYC),
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_btn (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .btn_i   (btn_i),
    .short_o (btn_short),
    .mid_o   (btn_mid),
    .long_o  (btn_long),
    .level_o ()
  );

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  pbw_pkg::pbw_core_t c_reg;
  pbw_pkg::pbw_core_t c_next;

  logic        usb_en;
  logic        deep;
  pbw_pkg::pbw_ac_t ac_pol;
  logic        os_sleep;
  logic        press;
  logic        sleeping;
  logic        wake_any;
  logic [2:0]  wake_cause;
  logic        disp_wake;
  logic        cmd_wr;

  assign usb_en   = c_reg.ctrl[pbw_pkg::PBW_CTRL_USBW];
  assign deep     = c_reg.ctrl[pbw_pkg::PBW_CTRL_DEEP];
  assign ac_pol   = pbw_pkg::pbw_ac_t'(c_reg.ctrl[pbw_pkg::PBW_CTRL_AC_LSB +: 2]);
  assign os_sleep = c_reg.ctrl[pbw_pkg::PBW_CTRL_OSSLP];
  assign cmd_wr   = wr_i && addr_i == pbw_pkg::PBW_REG_CMD;
  assign press    = btn_short || btn_mid || wk.cec;
  assign sleeping = c_reg.state == pbw_pkg::PBW_S3 ||
                    c_reg.state == pbw_pkg::PBW_S4 ||
                    c_reg.state == pbw_pkg::PBW_S5;

  // wake qualification per source and state
  always_comb begin
    wake_any   = 1'b0;
    wake_cause = 3'h0;
    disp_wake  = 1'b0;
    if (sleeping) begin
      if (press) begin
        wake_any   = 1'b1;
        wake_cause = 3'h1;
        disp_wake  = 1'b1;
      end else if (wk.rtc || wk.wifi) begin
        wake_any   = 1'b1;
        wake_cause = wk.rtc ? 3'h2 : 3'h3;
      end else if (wk.lan) begin
        wake_any   = 1'b1;
        wake_cause = 3'h4;
      end else if (wk.pcie && c_reg.state != pbw_pkg::PBW_S5) begin
        wake_any   = 1'b1;
        wake_cause = 3'h5;
      end else if (wk.usb && !c_reg.after_g3) begin
        if (c_reg.state == pbw_pkg::PBW_S3) begin
          wake_any   = 1'b1;
          wake_cause = 3'h6;
        end else if (usb_en && !deep) begin
          wake_any   = 1'b1;
          wake_cause = 3'h6;
        end
      end
    end
  end

  always_comb begin
    c_next           = c_reg;
    c_next.rdata     = 32'h0000_0000;
    if (wr_i && addr_i == pbw_pkg::PBW_REG_CTRL) begin
      c_next.ctrl = wdata_i;
    end
    if (rd_i) begin
      case (addr_i)
        pbw_pkg::PBW_REG_CTRL:  c_next.rdata = c_reg.ctrl;
        pbw_pkg::PBW_REG_STATE: c_next.rdata = {26'h0, c_reg.after_g3,
                                                 c_reg.cold_boot, c_reg.sleep_req,
                                                 c_reg.state};
        pbw_pkg::PBW_REG_CAUSE: c_next.rdata = {29'h0, c_reg.cause};
        default:                c_next.rdata = 32'h0000_0000;
      endcase
    end
    case (c_reg.state)
      pbw_pkg::PBW_G3: begin
        // policy applied once AC is back
        if (ac_ok) begin
          c_next.after_g3 = 1'b1;
          case (ac_pol)
            pbw_pkg::PBW_AC_ON: begin
              c_next.state     = pbw_pkg::PBW_S0;
              c_next.cold_boot = 1'b1;
            end
            pbw_pkg::PBW_AC_LAST: begin
              c_next.state     = c_reg.last == pbw_pkg::PBW_S0 ?
                                 pbw_pkg::PBW_S0 : pbw_pkg::PBW_S5;
              c_next.cold_boot = 1'b1;
            end
            default: c_next.state = pbw_pkg::PBW_S5;
          endcase
        end
      end
      pbw_pkg::PBW_S0: begin
        if (btn_long) begin
          c_next.state     = pbw_pkg::PBW_S5;
          c_next.sleep_req = 1'b0;
        end else if (btn_short || btn_mid || wk.cec) begin
          c_next.sleep_req = os_sleep;
        end
        // a forced off must not be undone by a sleep command in the same cycle
        if (!btn_long && cmd_wr && wdata_i[1:0] == pbw_pkg::PBW_CMD_SLEEP) begin
          // os chooses S3 or S4; anything else falls back to S3
          c_next.state     = wdata_i[2] ? pbw_pkg::PBW_S4 : pbw_pkg::PBW_S3;
          c_next.sleep_req = 1'b0;
          c_next.cold_boot = 1'b0;
        end else if (cmd_wr && wdata_i[1:0] == pbw_pkg::PBW_CMD_OFF) begin
          c_next.state     = pbw_pkg::PBW_S5;
          c_next.sleep_req = 1'b0;
        end
      end
      pbw_pkg::PBW_S3, pbw_pkg::PBW_S4, pbw_pkg::PBW_S5: begin
        if (btn_long && c_reg.state != pbw_pkg::PBW_S5) begin
          c_next.state = pbw_pkg::PBW_S5;
        end else if (wake_any) begin
          c_next.state     = pbw_pkg::PBW_S0;
          c_next.cause     = wake_cause;
          c_next.cold_boot = c_reg.state == pbw_pkg::PBW_S5;
          c_next.after_g3  = 1'b0;
        end
      end
      default: c_next.state = pbw_pkg::PBW_G3;
    endcase
    if (c_reg.state != pbw_pkg::PBW_G3) begin
      c_next.last = c_reg.state;
    end
    if (!ac_ok) begin
      c_next.state = pbw_pkg::PBW_G3;
      c_next.sleep_req = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_reg       <= '0;
      c_reg.state <= pbw_pkg::PBW_G3;
      c_reg.last  <= pbw_pkg::PBW_S5;
      c_reg.ctrl  <= pbw_pkg::PBW_CTRL_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic disp_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_reg <= 1'b0;
    end else if (c_reg.state != pbw_pkg::PBW_S0) begin
      disp_reg <= disp_wake;
    end else if (btn_short || btn_mid || wk.cec) begin
      disp_reg <= 1'b1;
    end
  end

  assign rdata_o      = c_reg.rdata;
  assign main_pwr_o   = c_reg.state == pbw_pkg::PBW_S0;
  assign wake_pwr_o   = c_reg.state != pbw_pkg::PBW_G3;
  assign display_on_o = main_pwr_o && disp_reg;
  assign cold_boot_o  = c_reg.cold_boot;
  assign sleep_req_o  = c_reg.sleep_req;
  assign state_o      = c_reg.state;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_long_off;
    @(posedge clk_i) disable iff (rst_i)
      btn_long && ac_ok && c_reg.state != pbw_pkg::PBW_G3 |=> state_o == pbw_pkg::PBW_S5;
  endproperty
  a_long_off: assert property (p_long_off) else $error("long hold did not force off");

  property p_short_wake;
    @(posedge clk_i) disable iff (rst_i)
      sleeping && btn_short && !btn_long && ac_ok |=> state_o == pbw_pkg::PBW_S0;
  endproperty
  a_short_wake: assert property (p_short_wake) else $error("short press did not wake");

  property p_cold;
    @(posedge clk_i) disable iff (rst_i)
      $past(c_reg.state) == pbw_pkg::PBW_S5 && state_o == pbw_pkg::PBW_S0 |-> cold_boot_o;
  endproperty
  a_cold: assert property (p_cold) else $error("exit from soft-off not cold");

  property p_rails;
    @(posedge clk_i) disable iff (rst_i)
      sleeping |-> !main_pwr_o && wake_pwr_o;
  endproperty
  a_rails: assert property (p_rails) else $error("rail state wrong while asleep");

  property p_cec;
    @(posedge clk_i) disable iff (rst_i)
      sleeping && wk.cec && !btn_long && ac_ok |=> state_o == pbw_pkg::PBW_S0 && display_on_o;
  endproperty
  a_cec: assert property (p_cec) else $error("display-link wake failed");

  property p_usb_g3;
    @(posedge clk_i) disable iff (rst_i)
      sleeping && c_reg.after_g3 && wk == 6'h04 && !press |=>
        state_o != pbw_pkg::PBW_S0;
  endproperty
  a_usb_g3: assert property (p_usb_g3) else $error("usb wake after mechanical off");

  property p_pcie_s5;
    @(posedge clk_i) disable iff (rst_i)
      c_reg.state == pbw_pkg::PBW_S5 && wk == 6'h02 && !btn_short && !btn_mid |=>
        state_o != pbw_pkg::PBW_S0;
  endproperty
  a_pcie_s5: assert property (p_pcie_s5) else $error("pcie woke from soft-off");

  property p_rtc_disp;
    @(posedge clk_i) disable iff (rst_i)
      sleeping && (wk.rtc || wk.wifi || wk.lan) && !press && !btn_long && ac_ok |=>
        state_o == pbw_pkg::PBW_S0 && !display_on_o;
  endproperty
  a_rtc_disp: assert property (p_rtc_disp) else $error("quiet wake lit display");

  property p_ac_off;
    @(posedge clk_i) disable iff (rst_i)
      c_reg.state == pbw_pkg::PBW_G3 && ac_ok && ac_pol == pbw_pkg::PBW_AC_OFF |=>
        state_o == pbw_pkg::PBW_S5;
  endproperty
  a_ac_off: assert property (p_ac_off) else $error("stay-off policy ignored");

  c_wake_lan: cover property (@(posedge clk_i) disable iff (rst_i)
    wake_any && wake_cause == 3'h4);
  c_sleep_s4: cover property (@(posedge clk_i) disable iff (rst_i)
    state_o == pbw_pkg::PBW_S4);
  c_force_off: cover property (@(posedge clk_i) disable iff (rst_i)
    btn_long && c_reg.state == pbw_pkg::PBW_S0);

endmodule

/* File: core/pbw_pkg.sv */
// package: states, wake sources, register map and timing for the power/wake controller
package pbw_pkg;

  // ------------------------------------------------------------
  // system power states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PBW_S0,
    PBW_S3,
    PBW_S4,
    PBW_S5,
    PBW_G3
  } pbw_state_t;

  typedef enum logic [1:0] {
    PBW_AC_ON,
    PBW_AC_OFF,
    PBW_AC_LAST
  } pbw_ac_t;

  // ------------------------------------------------------------
  // wake source inputs
  // ------------------------------------------------------------
  typedef struct packed {
    logic rtc;
    logic lan;
    logic wifi;
    logic usb;
    logic pcie;
    logic cec;
  } pbw_wake_t;

  localparam int PBW_NWAKE = 6;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] PBW_REG_CTRL   = 4'h0;
  localparam logic [3:0] PBW_REG_STATE  = 4'h4;
  localparam logic [3:0] PBW_REG_CAUSE  = 4'h8;
  localparam logic [3:0] PBW_REG_CMD    = 4'hc;

  // ctrl fields
  localparam int PBW_CTRL_USBW   = 0;
  localparam int PBW_CTRL_DEEP   = 1;
  localparam int PBW_CTRL_AC_LSB = 2;
  localparam int PBW_CTRL_OSSLP  = 4;
  localparam int PBW_CTRL_SLP_LSB = 5;

  localparam logic [31:0] PBW_CTRL_RST = 32'h0000_0031;

  // command register values
  localparam logic [1:0] PBW_CMD_NONE  = 2'h0;
  localparam logic [1:0] PBW_CMD_SLEEP = 2'h1;
  localparam logic [1:0] PBW_CMD_OFF   = 2'h2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint PBW_CLK_HZ     = 100_000_000;
  localparam longint PBW_SHORT_S    = 4;
  localparam longint PBW_LONG_S     = 6;
  localparam longint PBW_DEBOUNCE_US = 10;
  localparam longint PBW_SHORT_CYC  = PBW_SHORT_S * PBW_CLK_HZ;
  localparam longint PBW_LONG_CYC   = PBW_LONG_S * PBW_CLK_HZ;
  localparam longint PBW_DEB_CYC    = PBW_DEBOUNCE_US * PBW_CLK_HZ / 1_000_000;

  typedef struct packed {
    pbw_state_t state;
    pbw_state_t last;
    logic       after_g3;
    logic       cold_boot;
    logic       sleep_req;
    logic [2:0] cause;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic       ac_seen;
  } pbw_core_t;

endpackage

/* File: core/pbw_btn.sv */
// switch input: synchroniser, debouncer and hold timer
`timescale 1ns/1ps
module pbw_btn #(
  parameter int DEB_CYC   = 1000,            // debounce window
  parameter int SHORT_CYC = 400_000_000,     // short-press limit
  parameter int LONG_CYC  = 600_000_000      // forced-off hold
) (
  input  wire logic clk_i,                   // standby clock
  input  wire logic rst_i,                   // sync reset, high
  input  wire logic btn_i,                   // raw switch, high = pressed
  output logic      short_o,                 // pulse: released before short limit
  output logic      mid_o,                   // pulse: released between limits
  output logic      long_o,                  // pulse: hold reached long limit
  output logic      level_o                  // debounced level
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        lvl;
    logic [31:0] deb;
    logic [31:0] hold;
    logic        long_done;
    logic        sp;
    logic        mp;
    logic        lp;
  } pbw_btn_st_t;

  pbw_btn_st_t st_reg;
  pbw_btn_st_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.sp = 1'b0;
    st_next.mp = 1'b0;
    st_next.lp = 1'b0;
    st_next.s1 = btn_i;
    st_next.s2 = st_reg.s1;
    // level must stay stable for the full window before it is believed
    if (st_reg.s2 != st_reg.lvl) begin
      if (st_reg.deb >= 32'(DEB_CYC - 1)) begin
        st_next.lvl = st_reg.s2;
        st_next.deb = 32'h0000_0000;
      end else begin
        st_next.deb = st_reg.deb + 32'h0000_0001;
      end
    end else begin
      st_next.deb = 32'h0000_0000;
    end
    if (st_reg.lvl) begin
      if (st_reg.hold != 32'hffff_ffff) begin
        st_next.hold = st_reg.hold + 32'h0000_0001;
      end
      if (st_reg.hold == 32'(LONG_CYC - 1) && !st_reg.long_done) begin
        st_next.lp        = 1'b1;
        st_next.long_done = 1'b1;
      end
    end else begin
      st_next.hold      = 32'h0000_0000;
      st_next.long_done = 1'b0;
    end
    if (st_reg.lvl && !st_next.lvl && !st_reg.long_done) begin
      if (st_reg.hold < 32'(SHORT_CYC)) begin
        st_next.sp = 1'b1;
      end else begin
        st_next.mp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign short_o = st_reg.sp;
  assign mid_o   = st_reg.mp;
  assign long_o  = st_reg.lp;
  assign level_o = st_reg.lvl;

endmodule

/* File: tb/pbw_far.sv */
// far-side model: power switch, wake sources and mains supply
`timescale 1ns/1ps
module pbw_far (
  input  wire logic          clk_i,   // standby clock
  output logic               btn_o,   // switch, high = pressed
  output logic               ac_ok_o, // mains present
  output pbw_pkg::pbw_wake_t wake_o,  // wake request levels
  output logic [3:0]         addr_o,  // os register address
  output logic [31:0]        wdata_o, // os write data
  output logic               wr_o,    // os write strobe
  output logic               rd_o,    // os read strobe
  input  wire logic [31:0]   rdata_i  // read data from the controller
);
  initial begin
    btn_o   = 1'b0;
    ac_ok_o = 1'b0;
    wake_o  = '0;
    addr_o  = 4'h0;
    wdata_o = 32'h0000_0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // ------------------------------------------------------------
  // operating system side of the register port
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask

  // ------------------------------------------------------------
  // stimulus tasks, all launched just after a rising edge
  // ------------------------------------------------------------
  // contacts are ideal: bounce is not modelled
  task automatic press(input int n);
    @(posedge clk_i);
    btn_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    btn_o <= 1'b0;
  endtask

  task automatic set_btn(input logic v);
    @(posedge clk_i);
    btn_o <= v;
  endtask

  // a source keeps its request as a level until told to drop it
  task automatic raise(input logic [5:0] m);
    @(posedge clk_i);
    wake_o <= pbw_pkg::pbw_wake_t'(m);
  endtask

  task automatic set_ac(input logic v);
    @(posedge clk_i);
    ac_ok_o <= v;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the power/wake controller
`timescale 1ns/1ps
module testbench;
  logic               clk_i;
  logic               rst_i;
  logic [3:0]         addr_i;
  logic [31:0]        wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic [31:0]        rdata_o;
  logic               main_pwr_o;
  logic               wake_pwr_o;
  logic               display_on_o;
  logic               cold_boot_o;
  logic               sleep_req_o;
  pbw_pkg::pbw_state_t state_o;
  logic               btn;
  logic               ac_ok;
  pbw_pkg::pbw_wake_t wake;
  logic [31:0]        v;
  int                 errors;
  int                 n_checks;

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  pbw_far far (
    .clk_i(clk_i), .btn_o(btn), .ac_ok_o(ac_ok), .wake_o(wake),
    .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o)
  );

  // short counts keep the run small; press lengths below follow them
  pbw_ctrl #(.DEB_CYC(4), .SHORT_CYC(40), .LONG_CYC(60)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .btn_i(btn), .ac_ok_i(ac_ok), .wake_i(wake),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .main_pwr_o(main_pwr_o), .wake_pwr_o(wake_pwr_o), .display_on_o(display_on_o),
    .cold_boot_o(cold_boot_o), .sleep_req_o(sleep_req_o), .state_o(state_o)
  );

  // ------------------------------------------------------------
  // common tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the register port is driven by the os side of the far model
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    far.wr(a, d);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    far.rd(a, d);
  endtask

  // bounded wait for a state, then compare
  task automatic st(input pbw_pkg::pbw_state_t e);
    int i;
    for (i = 0; i < 300 && state_o !== e; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(32'(state_o), 32'(e));
    if (i == 300) begin
      finish_test();
    end
  endtask

  // a refused request must leave the state alone
  task automatic stay(input pbw_pkg::pbw_state_t e);
    repeat (30) @(posedge clk_i);
    #1;
    chk(32'(state_o), 32'(e));
  endtask

  // bounded wait for the sleep request, then compare
  task automatic wait_req();
    int i;
    for (i = 0; i < 100 && sleep_req_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(32'(sleep_req_o), 32'h0000_0001);
    if (i == 100) begin
      finish_test();
    end
  endtask

  task automatic go(input logic [31:0] cmd, input pbw_pkg::pbw_state_t e);
    wr(pbw_pkg::PBW_REG_CMD, cmd);
    st(e);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(32'(state_o), 32'(pbw_pkg::PBW_G3));
    chk(32'(wake_pwr_o), 32'h0000_0000);
    rd(pbw_pkg::PBW_REG_CTRL, v);
    chk(v, pbw_pkg::PBW_CTRL_RST);
    rd(4'h2, v);
    chk(v, 32'h0000_0000);
    far.set_ac(1'b1);
    st(pbw_pkg::PBW_S0);
    chk(32'(cold_boot_o), 32'h0000_0001);
    chk(32'(main_pwr_o), 32'h0000_0001);
    rd(pbw_pkg::PBW_REG_STATE, v);
    chk(v, 32'h0000_0030);
  endtask

  task automatic t_sleep_wakes();
    go(32'h0000_0001, pbw_pkg::PBW_S3);
    chk(32'({main_pwr_o, wake_pwr_o}), 32'h0000_0001);
    far.raise(6'h04);
    stay(pbw_pkg::PBW_S3);
    far.raise(6'h10);
    st(pbw_pkg::PBW_S0);
    chk(32'({display_on_o, cold_boot_o}), 32'h0000_0000);
    rd(pbw_pkg::PBW_REG_CAUSE, v);
    chk(v, 32'h0000_0004);
    far.raise(6'h00);
    go(32'h0000_0001, pbw_pkg::PBW_S3);
    far.raise(6'h04);
    st(pbw_pkg::PBW_S0);
    rd(pbw_pkg::PBW_REG_CAUSE, v);
    chk(v, 32'h0000_0006);
    far.raise(6'h00);
  endtask

  task automatic t_pcie_rtc();
    go(32'h0000_0005, pbw_pkg::PBW_S4);
    far.raise(6'h02);
    st(pbw_pkg::PBW_S0);
    chk(32'(display_on_o), 32'h0000_0000);
    far.raise(6'h00);
    go(32'h0000_0002, pbw_pkg::PBW_S5);
    far.raise(6'h02);
    stay(pbw_pkg::PBW_S5);
    far.raise(6'h20);
    st(pbw_pkg::PBW_S0);
    chk(32'({display_on_o, cold_boot_o}), 32'h0000_0001);
    far.raise(6'h00);
  endtask

  task automatic t_usb_gate();
    wr(pbw_pkg::PBW_REG_CTRL, 32'h0000_0033);
    go(32'h0000_0005, pbw_pkg::PBW_S4);
    far.raise(6'h04);
    stay(pbw_pkg::PBW_S4);
    far.raise(6'h08);
    st(pbw_pkg::PBW_S0);
    rd(pbw_pkg::PBW_REG_CAUSE, v);
    chk(v, 32'h0000_0003);
    far.raise(6'h00);
    wr(pbw_pkg::PBW_REG_CTRL, 32'h0000_0030);
    go(32'h0000_0005, pbw_pkg::PBW_S4);
    far.raise(6'h04);
    stay(pbw_pkg::PBW_S4);
    far.raise(6'h00);
    wr(pbw_pkg::PBW_REG_CTRL, 32'h0000_0031);
    far.raise(6'h04);
    st(pbw_pkg::PBW_S0);
    far.raise(6'h00);
  endtask

  task automatic t_switch();
    far.press(10);
    wait_req();
    go(32'h0000_0001, pbw_pkg::PBW_S3);
    chk(32'(sleep_req_o), 32'h0000_0000);
    far.press(10);
    st(pbw_pkg::PBW_S0);
    chk(32'(display_on_o), 32'h0000_0001);
    go(32'h0000_0002, pbw_pkg::PBW_S5);
    far.raise(6'h01);
    st(pbw_pkg::PBW_S0);
    chk(32'(display_on_o), 32'h0000_0001);
    far.raise(6'h00);
    go(32'h0000_0001, pbw_pkg::PBW_S3);
    far.press(50);
    st(pbw_pkg::PBW_S0);
    far.press(50);
    wait_req();
    go(32'h0000_0001, pbw_pkg::PBW_S3);
    far.set_btn(1'b1);
    st(pbw_pkg::PBW_S5);
    far.set_btn(1'b0);
    // let the release pass the debouncer, or the next press merges with the hold
    repeat (20) @(posedge clk_i);
    far.press(10);
    st(pbw_pkg::PBW_S0);
    far.set_btn(1'b1);
    st(pbw_pkg::PBW_S5);
    far.set_btn(1'b0);
    stay(pbw_pkg::PBW_S5);
  endtask

  task automatic t_ac();
    far.press(10);
    st(pbw_pkg::PBW_S0);
    wr(pbw_pkg::PBW_REG_CTRL, 32'h0000_0039);
    far.set_ac(1'b0);
    st(pbw_pkg::PBW_G3);
    chk(32'({main_pwr_o, wake_pwr_o}), 32'h0000_0000);
    far.set_ac(1'b1);
    st(pbw_pkg::PBW_S0);
    wr(pbw_pkg::PBW_REG_CTRL, 32'h0000_0035);
    far.set_ac(1'b0);
    st(pbw_pkg::PBW_G3);
    far.set_ac(1'b1);
    st(pbw_pkg::PBW_S5);
    far.raise(6'h04);
    stay(pbw_pkg::PBW_S5);
    far.raise(6'h10);
    st(pbw_pkg::PBW_S0);
    chk(32'(display_on_o), 32'h0000_0000);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    errors   = 0;
    n_checks = 0;
    rst_i    = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_sleep_wakes();
    t_pcie_rtc();
    t_usb_gate();
    t_switch();
    t_ac();
    finish_test();
  end
endmodule
